/* File: include/acc_pkg.sv */
// Shared constants and carrier types for the comparator control block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
package acc_pkg;

  // Structure.
  localparam int ACC_NUM_CH      = 2;
  localparam int ACC_AW          = 8;
  localparam int ACC_DW          = 32;
  localparam int ACC_PLUS_ROUTES = 4;
  localparam int ACC_MINUS_CODES = 8;

  // Register byte offsets; channel registers repeat every stride.
  localparam logic [ACC_AW-1:0] ACC_OFF_CFG_BASE = 8'h00;
  localparam logic [ACC_AW-1:0] ACC_OFF_SEL_BASE = 8'h04;
  localparam logic [ACC_AW-1:0] ACC_CH_STRIDE    = 8'h08;
  localparam logic [ACC_AW-1:0] ACC_OFF_MIRROR   = 8'h10;
  localparam logic [ACC_AW-1:0] ACC_OFF_FLAG     = 8'h14;
  localparam logic [ACC_AW-1:0] ACC_OFF_IRQ_EN   = 8'h18;

  // Bit positions of comparator_config.
  localparam int ACC_CFG_EN_BIT   = 7;
  localparam int ACC_CFG_OUT_BIT  = 6;
  localparam int ACC_CFG_POL_BIT  = 4;
  localparam int ACC_CFG_SP_BIT   = 2;
  localparam int ACC_CFG_HYS_BIT  = 1;
  localparam int ACC_CFG_SYNC_BIT = 0;

  // Bit positions of comparator_input_select.
  localparam int ACC_SEL_RISE_BIT  = 7;
  localparam int ACC_SEL_FALL_BIT  = 6;
  localparam int ACC_SEL_PLUS_LSB  = 4;
  localparam int ACC_SEL_MINUS_LSB = 0;

  // Bit positions of the interrupt enable register.
  localparam int ACC_IRQ_GLOBAL_BIT = 7;
  localparam int ACC_IRQ_PERIPH_BIT = 6;

  // Input routing codes.
  localparam logic [1:0] ACC_PLUS_PIN     = 2'h0;
  localparam logic [1:0] ACC_PLUS_DAC     = 2'h1;
  localparam logic [1:0] ACC_PLUS_REF2    = 2'h2;
  localparam logic [1:0] ACC_PLUS_GND     = 2'h3;
  localparam logic [2:0] ACC_MINUS_RSVD_A = 3'h4;
  localparam logic [2:0] ACC_MINUS_RSVD_B = 3'h5;
  localparam logic [2:0] ACC_MINUS_REF2   = 3'h6;
  localparam logic [2:0] ACC_MINUS_GND    = 3'h7;
  localparam logic [ACC_PLUS_ROUTES-1:0] ACC_PLUS_ONE  = 4'h1;
  localparam logic [ACC_MINUS_CODES-1:0] ACC_MINUS_ONE = 8'h01;

  // AXI responses.
  localparam logic [1:0] ACC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

  // Configuration fields of one channel.
  typedef struct packed {
    logic enable;
    logic invert;
    logic speed;
    logic hysteresis;
    logic sync;
  } acc_cfg_t;

  // Input and edge selection of one channel.
  typedef struct packed {
    logic       rise_en;
    logic       fall_en;
    logic [1:0] plus_sel;
    logic [2:0] minus_sel;
  } acc_sel_t;

  // Controls driven into the analog comparator of one channel.
  typedef struct packed {
    logic                       power;
    logic                       speed_high;
    logic                       hysteresis;
    logic [ACC_PLUS_ROUTES-1:0] plus_route;
    logic [ACC_MINUS_CODES-1:0] minus_route;
  } acc_analog_t;

  localparam acc_cfg_t ACC_CFG_RESET = '{enable: 1'b0, invert: 1'b0, speed: 1'b1,
                                         hysteresis: 1'b0, sync: 1'b0};
  localparam acc_sel_t ACC_SEL_RESET = '{rise_en: 1'b0, fall_en: 1'b0,
                                         plus_sel: 2'h0, minus_sel: 3'h0};

endpackage : acc_pkg

/* File: test/acc_comparator_ctrl_properties.sv */
// Port checks for the comparator control block.
// Assumes it is bound to acc_comparator_ctrl, whose port names it reuses.
`timescale 1ns/1ps

module acc_comparator_ctrl_properties
  import acc_pkg::*;
(
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Register bus
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  // Comparator side
  input wire acc_analog_t [ACC_NUM_CH-1:0] analog_ctrl,
  input wire logic [ACC_NUM_CH-1:0]   tmr1_gate,
  input wire logic [ACC_NUM_CH-1:0]   compare_pin,
  input wire logic [ACC_NUM_CH-1:0]   irq_request
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  for (genvar i = 0; i < ACC_NUM_CH; i++) begin : g_ch
    routes_off_a: assert property (
      !analog_ctrl[i].power |-> analog_ctrl[i].plus_route == '0 && analog_ctrl[i].minus_route == '0)
      else $error("inputs connected while powered down");
    routes_onehot_a: assert property (
      analog_ctrl[i].power |-> $onehot(analog_ctrl[i].plus_route)
        && $onehot0(analog_ctrl[i].minus_route) && analog_ctrl[i].minus_route[5:4] == 2'b00)
      else $error("bad input routing");
    irq_needs_power_a: assert property (
      irq_request[i] |-> analog_ctrl[i].power)
      else $error("request from a disabled comparator");
  end

  pin_gate_a: assert property (tmr1_gate == compare_pin)
    else $error("pin and gate differ");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  bresp_release_a: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response dropped early");
  rdata_release_a: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data dropped early");
  busy_ready_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted during response");

  cover property ($rose(irq_request[0]));
  cover property ($rose(tmr1_gate[0]));
  cover property ($fell(tmr1_gate[0]));
endmodule : acc_comparator_ctrl_properties

bind acc_comparator_ctrl acc_comparator_ctrl_properties u_props (.*);

/* File: test/acc_comparator_ctrl_test.sv */
// Self-checking bench for the comparator control block.
// Assumes the Timer1 clock model and the port checker are compiled first.
`timescale 1ns/1ps

module acc_comparator_ctrl_test;
  import acc_pkg::*;

  logic              aclk, aresetn, tmr1_src_clk, tmr1_prescaled_clk, tmr1_prescale_on;
  logic [ACC_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [ACC_DW-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, analog_above, tmr1_gate, compare_pin, irq_request;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              run_src, run_pre;
  acc_analog_t [1:0] analog_ctrl;
  int                fails, n_checks;

  acc_comparator_ctrl uut (.*);
  acc_tmr1_model u_tmr1 (.aclk(aclk), .aresetn(aresetn), .run_src(run_src),
    .run_pre(run_pre), .src_clk(tmr1_src_clk), .pre_clk(tmr1_prescaled_clk));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic give_verdict;
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // Every handshake and gate wait goes through here so a hung handshake still ends the run.
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 200) begin
      fails++;
      $display("Error at %0t: no answer", $time);
      give_verdict();
    end
  endtask : tick

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = 2'h0);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, e});
    chk(s_axi_rresp, er);
    @(posedge aclk);
  endtask : axi_rd

  task automatic wait_gate(input logic v);
    int n;
    n = 0;
    while (tmr1_gate[0] !== v) tick(n);
    chk(tmr1_gate[0], v);
    chk(compare_pin[0], v);
  endtask : wait_gate

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {analog_above, tmr1_prescale_on, run_src, run_pre, aresetn} = '0;
    s_axi_wstrb = 4'hf;
    fails = 0;
    n_checks = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 4; i++) begin
      axi_rd(8'(i * 4), i[0] ? 8'h00 : 8'h04);
    end
    axi_wr(8'h00, 8'hff);
    axi_wr(8'h04, 8'hff);
    repeat (4) @(posedge aclk);
    axi_rd(8'h00, 8'hd7);
    axi_rd(8'h04, 8'hf7);
    axi_wr(8'h00, 8'h87);
    chk({analog_ctrl[0].power, analog_ctrl[0].speed_high, analog_ctrl[0].hysteresis}, 3'h7);
    for (int c = 0; c < 8; c++) begin
      axi_wr(8'h04, {2'b00, c[1:0], 1'b0, c[2:0]});
      chk(analog_ctrl[0].plus_route, 4'h1 << c[1:0]);
      chk(analog_ctrl[0].minus_route, c inside {4, 5} ? 8'h00 : 8'h01 << c[2:0]);
    end
    axi_wr(8'h00, 8'h80);
    chk({analog_ctrl[0].power, analog_ctrl[0].speed_high, analog_ctrl[0].hysteresis}, 3'h4);
    axi_wr(8'h00, 8'h00);
    chk({analog_ctrl[0].power, analog_ctrl[0].plus_route, analog_ctrl[0].minus_route}, 32'h0);
    axi_wr(8'h40, 8'h01, ACC_RESP_SLVERR);
    axi_rd(8'h40, 8'h00, ACC_RESP_SLVERR);
    analog_above <= 2'b01;
    axi_wr(8'h00, 8'h80);
    axi_wr(8'h08, 8'h90);
    repeat (4) @(posedge aclk);
    axi_rd(8'h00, 8'hc0);
    axi_rd(8'h08, 8'hd0);
    axi_rd(8'h10, 8'h03);
    axi_wr(8'h18, 8'hc1);
    axi_wr(8'h04, 8'h40);
    axi_wr(8'h14, 8'h00);
    analog_above <= 2'b00;
    repeat (6) @(posedge aclk);
    axi_rd(8'h14, 8'h01);
    chk(irq_request, 2'b01);
    axi_wr(8'h04, 8'h80);
    axi_wr(8'h18, 8'h41);
    axi_wr(8'h14, 8'h00);
    analog_above <= 2'b01;
    // The clear below lands on the very edge at which the synced rise sets the flag.
    @(posedge aclk);
    axi_wr(8'h14, 8'h00);
    axi_rd(8'h14, 8'h01);
    chk(irq_request, 2'b00);
    axi_wr(8'h18, 8'h81);
    axi_rd(8'h18, 8'h81);
    chk(irq_request, 2'b00);
    axi_wr(8'h14, 8'h00);
    analog_above <= 2'b00;
    repeat (6) @(posedge aclk);
    axi_rd(8'h14, 8'h00);
    axi_wr(8'h00, 8'h00);
    axi_wr(8'h14, 8'h00);
    axi_wr(8'h00, 8'h10);
    repeat (4) @(posedge aclk);
    axi_rd(8'h14, 8'h01);
    axi_wr(8'h18, 8'hc1);
    chk(irq_request, 2'b00);
    axi_wr(8'h00, 8'h80);
    analog_above <= 2'b01;
    wait_gate(1'b1);
    axi_wr(8'h00, 8'h81);
    analog_above <= 2'b00;
    repeat (20) @(posedge aclk);
    chk(tmr1_gate[0], 1'b1);
    run_src <= 1'b1;
    wait_gate(1'b0);
    // Switch selection only while the raw clock is low, or the switch looks like a fall.
    for (int n = 0; tmr1_src_clk !== 1'b0; ) begin
      tick(n);
    end
    tmr1_prescale_on <= 1'b1;
    analog_above <= 2'b01;
    repeat (20) @(posedge aclk);
    chk(tmr1_gate[0], 1'b0);
    run_pre <= 1'b1;
    wait_gate(1'b1);
    give_verdict();
  end
endmodule : acc_comparator_ctrl_test

/* File: test/acc_tmr1_model.sv */
// Timer1 clock source facing the comparator block: raw and prescaled clocks.
// Assumes levels sampled on aclk; both clocks stand still while not running.
`timescale 1ns/1ps

module acc_tmr1_model (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Run controls
  input  wire logic run_src,
  input  wire logic run_pre,
  // Timer1 clocks
  output logic      src_clk,
  output logic      pre_clk
);
  logic [1:0] div;
  wire        edge_due = run_src && div == 2'h3;

  // The prescaler only advances on a raw rising edge, so it never runs ahead.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div     <= 2'h0;
      src_clk <= 1'b0;
      pre_clk <= 1'b0;
    end else begin
      if (run_src) begin
        div <= div + 2'h1;
      end
      if (edge_due) begin
        src_clk <= !src_clk;
      end
      if (edge_due && !src_clk && run_pre) begin
        pre_clk <= !pre_clk;
      end
    end
  end
endmodule : acc_tmr1_model

/* File: verilog/acc_comparator_ctrl.sv */
// Digital control of two analog comparators: configuration registers, input
// routing, Timer1 synchronised output and edge interrupt flags.
// Assumes an AXI4-Lite master and the Timer1 clock levels on aclk, and raw
// compare results that are asynchronous.
`timescale 1ns/1ps

module acc_comparator_ctrl
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write address
  input  wire logic [ACC_AW-1:0]       s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [ACC_DW-1:0]       s_axi_wdata,
  input  wire logic [ACC_DW/8-1:0]     s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ACC_AW-1:0]       s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // AXI4-Lite read data
  output logic [ACC_DW-1:0]            s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Analog comparator cores
  input  wire logic [ACC_NUM_CH-1:0]   analog_above,
  output acc_analog_t [ACC_NUM_CH-1:0] analog_ctrl,
  // Timer1 clocking
  input  wire logic                    tmr1_src_clk,
  input  wire logic                    tmr1_prescaled_clk,
  input  wire logic                    tmr1_prescale_on,
  // Comparator outputs to Timer1 gate and pin
  output logic [ACC_NUM_CH-1:0]        tmr1_gate,
  output logic [ACC_NUM_CH-1:0]        compare_pin,
  // Interrupt requests
  output logic [ACC_NUM_CH-1:0]        irq_request
);

  // Write channel state.
  logic              aw_full;
  logic              w_full;
  logic [ACC_AW-1:0] aw_addr_q;
  logic [ACC_DW-1:0] w_data_q;
  logic              w_lane0_q;

  // Shared registers.
  logic [ACC_NUM_CH-1:0] compare_irq_flag;
  logic [ACC_NUM_CH-1:0] compare_irq_enable;
  logic                  peripheral_irq_enable;
  logic                  global_irq_enable;
  logic [ACC_NUM_CH-1:0] result_prev;
  logic                  tmr_clk_prev;
  logic [ACC_NUM_CH-1:0] gate_q;

  // Per-channel combinational results.
  logic [ACC_NUM_CH-1:0]         compare_result;
  logic [ACC_NUM_CH-1:0]         above_sync;
  logic [ACC_NUM_CH-1:0]         edge_set;
  logic [ACC_NUM_CH-1:0]         next_flag;
  logic [ACC_NUM_CH-1:0]         next_gate;
  logic [ACC_NUM_CH-1:0]         next_irq;
  logic [ACC_NUM_CH-1:0]         chan_cfg_en;
  acc_analog_t [ACC_NUM_CH-1:0]  next_analog;
  logic [ACC_NUM_CH-1:0][7:0]    rd_chan_byte;
  logic [ACC_NUM_CH-1:0]         rd_chan_hit;
  logic [ACC_NUM_CH-1:0]         wr_chan_hit;
  logic [7:0]                    rd_chan_or;
  logic                          rd_chan_any;

  // Bus handshakes and decode.
  wire logic       aw_take    = s_axi_awvalid & s_axi_awready;
  wire logic       w_take     = s_axi_wvalid & s_axi_wready;
  wire logic       wr_fire    = aw_full & w_full & ~s_axi_bvalid;
  wire logic       b_done     = s_axi_bvalid & s_axi_bready;
  wire logic       ar_take    = s_axi_arvalid & s_axi_arready;
  wire logic       r_done     = s_axi_rvalid & s_axi_rready;
  wire logic [7:0] w_byte     = w_data_q[7:0];
  wire logic       wr_byte_ok = wr_fire & w_lane0_q;
  wire logic       wr_flag    = wr_byte_ok & (aw_addr_q == ACC_OFF_FLAG);
  wire logic       wr_irq_en  = wr_byte_ok & (aw_addr_q == ACC_OFF_IRQ_EN);
  wire logic       wr_mirror  = aw_addr_q == ACC_OFF_MIRROR;
  wire logic       wr_hit     = (|wr_chan_hit) | wr_mirror
                                | (aw_addr_q == ACC_OFF_FLAG)
                                | (aw_addr_q == ACC_OFF_IRQ_EN);
  wire logic       rd_mirror  = s_axi_araddr == ACC_OFF_MIRROR;
  wire logic       rd_flag    = s_axi_araddr == ACC_OFF_FLAG;
  wire logic       rd_irq_en  = s_axi_araddr == ACC_OFF_IRQ_EN;
  wire logic       rd_hit     = rd_chan_any | rd_mirror | rd_flag | rd_irq_en;

  // Timer1 latch clock and its falling edge.
  wire logic tmr_clk_sel = tmr1_prescale_on ? tmr1_prescaled_clk : tmr1_src_clk;
  wire logic tmr_fall    = tmr_clk_prev & ~tmr_clk_sel;

  // Interrupt enable byte as software sees it.
  logic [7:0] irq_en_byte;
  always_comb begin
    irq_en_byte                     = '0;
    irq_en_byte[ACC_NUM_CH-1:0]     = compare_irq_enable;
    irq_en_byte[ACC_IRQ_PERIPH_BIT] = peripheral_irq_enable;
    irq_en_byte[ACC_IRQ_GLOBAL_BIT] = global_irq_enable;
  end

  // The analog result is asynchronous; it is only ever used after two flops.
  acc_sync2 u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (analog_above),
    .sync_out (above_sync)
  );

  genvar g;
  generate
    for (g = 0; g < ACC_NUM_CH; g++) begin : g_chan
      localparam logic [ACC_AW-1:0] CFG_OFF = ACC_AW'(ACC_OFF_CFG_BASE + g * ACC_CH_STRIDE);
      localparam logic [ACC_AW-1:0] SEL_OFF = ACC_AW'(ACC_OFF_SEL_BASE + g * ACC_CH_STRIDE);

      acc_cfg_t cfg_q;
      acc_sel_t sel_q;
      acc_cfg_t next_cfg;
      acc_sel_t next_sel;
      logic [7:0] cfg_byte;
      logic [7:0] sel_byte;

      wire logic cfg_wr = wr_byte_ok & (aw_addr_q == CFG_OFF);
      wire logic sel_wr = wr_byte_ok & (aw_addr_q == SEL_OFF);
      wire logic rd_cfg = s_axi_araddr == CFG_OFF;
      wire logic rd_sel = s_axi_araddr == SEL_OFF;
      wire logic rise   = compare_result[g] & ~result_prev[g];
      wire logic fall   = ~compare_result[g] & result_prev[g];
      wire logic minus_ok = (sel_q.minus_sel != ACC_MINUS_RSVD_A)
                            & (sel_q.minus_sel != ACC_MINUS_RSVD_B);

      // The result bit itself is never stored from a write.
      assign next_cfg = '{enable:     w_byte[ACC_CFG_EN_BIT],
                          invert:     w_byte[ACC_CFG_POL_BIT],
                          speed:      w_byte[ACC_CFG_SP_BIT],
                          hysteresis: w_byte[ACC_CFG_HYS_BIT],
                          sync:       w_byte[ACC_CFG_SYNC_BIT]};
      assign next_sel = '{rise_en:   w_byte[ACC_SEL_RISE_BIT],
                          fall_en:   w_byte[ACC_SEL_FALL_BIT],
                          plus_sel:  w_byte[ACC_SEL_PLUS_LSB +: 2],
                          minus_sel: w_byte[ACC_SEL_MINUS_LSB +: 3]};

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cfg_q <= ACC_CFG_RESET;
          sel_q <= ACC_SEL_RESET;
        end else begin
          if (cfg_wr) begin
            cfg_q <= next_cfg;
          end
          if (sel_wr) begin
            sel_q <= next_sel;
          end
        end
      end

      // A disabled comparator outputs low before the polarity stage, so toggling
      // the polarity, or the enable while the synced input is high, moves the result and can flag an edge.
      assign compare_result[g] = (cfg_q.enable & above_sync[g]) ^ cfg_q.invert;
      assign edge_set[g]  = (rise & sel_q.rise_en) | (fall & sel_q.fall_en);
      assign chan_cfg_en[g] = cfg_q.enable;

      // Sync mode holds the output between Timer1 clock falls.
      assign next_gate[g] = cfg_q.sync ? (tmr_fall ? compare_result[g] : gate_q[g])
                                       : compare_result[g];

      // Every switch opens while the comparator is off.
      assign next_analog[g].power       = cfg_q.enable;
      assign next_analog[g].speed_high  = cfg_q.speed;
      assign next_analog[g].hysteresis  = cfg_q.hysteresis;
      assign next_analog[g].plus_route  = cfg_q.enable ? (ACC_PLUS_ONE << sel_q.plus_sel)
                                                       : '0;
      assign next_analog[g].minus_route = (cfg_q.enable & minus_ok)
                                          ? (ACC_MINUS_ONE << sel_q.minus_sel) : '0;

      always_comb begin
        cfg_byte                   = '0;
        cfg_byte[ACC_CFG_EN_BIT]   = cfg_q.enable;
        cfg_byte[ACC_CFG_OUT_BIT]  = compare_result[g];
        cfg_byte[ACC_CFG_POL_BIT]  = cfg_q.invert;
        cfg_byte[ACC_CFG_SP_BIT]   = cfg_q.speed;
        cfg_byte[ACC_CFG_HYS_BIT]  = cfg_q.hysteresis;
        cfg_byte[ACC_CFG_SYNC_BIT] = cfg_q.sync;
        sel_byte                   = '0;
        sel_byte[ACC_SEL_RISE_BIT] = sel_q.rise_en;
        sel_byte[ACC_SEL_FALL_BIT] = sel_q.fall_en;
        sel_byte[ACC_SEL_PLUS_LSB +: 2]  = sel_q.plus_sel;
        sel_byte[ACC_SEL_MINUS_LSB +: 3] = sel_q.minus_sel;
      end

      assign rd_chan_byte[g] = (rd_cfg ? cfg_byte : '0) | (rd_sel ? sel_byte : '0);
      assign rd_chan_hit[g]  = rd_cfg | rd_sel;
      assign wr_chan_hit[g]  = (aw_addr_q == CFG_OFF) | (aw_addr_q == SEL_OFF);
    end
  endgenerate

  // A software write replaces the flag but a same-cycle edge always wins.
  assign next_flag = edge_set | (wr_flag ? w_byte[ACC_NUM_CH-1:0] : compare_irq_flag);
  assign next_irq  = compare_irq_flag & compare_irq_enable & chan_cfg_en
                     & {ACC_NUM_CH{peripheral_irq_enable & global_irq_enable}};

  always_comb begin
    rd_chan_or  = '0;
    rd_chan_any = 1'b0;
    for (int i = 0; i < ACC_NUM_CH; i++) begin
      rd_chan_or  = rd_chan_or | rd_chan_byte[i];
      rd_chan_any = rd_chan_any | rd_chan_hit[i];
    end
  end

  wire logic [7:0] rd_byte = rd_chan_or
                             | (rd_mirror ? 8'(compare_result) : 8'h00)
                             | (rd_flag ? 8'(compare_irq_flag) : 8'h00)
                             | (rd_irq_en ? irq_en_byte : 8'h00);

  // Write address channel; refused until the response is accepted.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_full       <= 1'b0;
      aw_addr_q     <= '0;
    end else if (aw_take) begin
      s_axi_awready <= 1'b0;
      aw_full       <= 1'b1;
      aw_addr_q     <= s_axi_awaddr;
    end else begin
      if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (b_done) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // Write data channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_full       <= 1'b0;
      w_data_q     <= '0;
      w_lane0_q    <= 1'b0;
    end else if (w_take) begin
      s_axi_wready <= 1'b0;
      w_full       <= 1'b1;
      w_data_q     <= s_axi_wdata;
      w_lane0_q    <= s_axi_wstrb[0];
    end else begin
      if (wr_fire) begin
        w_full <= 1'b0;
      end
      if (b_done) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ACC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel; one read under way at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= ACC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= ACC_DW'(rd_byte);
      s_axi_rresp   <= rd_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
    end else if (r_done) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Interrupt enables.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_irq_enable    <= '0;
      peripheral_irq_enable <= 1'b0;
      global_irq_enable     <= 1'b0;
    end else if (wr_irq_en) begin
      compare_irq_enable    <= w_byte[ACC_NUM_CH-1:0];
      peripheral_irq_enable <= w_byte[ACC_IRQ_PERIPH_BIT];
      global_irq_enable     <= w_byte[ACC_IRQ_GLOBAL_BIT];
    end
  end

  // Status, edge history, Timer1 latch and registered outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_irq_flag <= '0;
      result_prev      <= '0;
      tmr_clk_prev     <= 1'b0;
      gate_q           <= '0;
      analog_ctrl      <= '0;
      irq_request      <= '0;
    end else begin
      compare_irq_flag <= next_flag;
      result_prev      <= compare_result;
      tmr_clk_prev     <= tmr_clk_sel;
      gate_q           <= next_gate;
      analog_ctrl      <= next_analog;
      irq_request      <= next_irq;
    end
  end

  // Timer1 gate and pin share one flop, so they never disagree.
  assign tmr1_gate   = gate_q;
  assign compare_pin = gate_q;

endmodule : acc_comparator_ctrl

/* File: verilog/acc_sync2.sv */
// Two-stage synchroniser for a vector of independent levels.
// Assumes each bit changes slowly relative to aclk; bits are not coherent.
`timescale 1ns/1ps

module acc_sync2
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // Levels
  input  wire logic [ACC_NUM_CH-1:0] async_in,
  output logic      [ACC_NUM_CH-1:0] sync_out
);

  logic [ACC_NUM_CH-1:0] stage1;

  // The first stage feeds only the second, so a metastable value never fans out.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : acc_sync2
